// ==== rtl/ctbs_pkg.sv ====
package ctbs_pkg;
	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
	localparam logic [7:0] ADDR_TIME_BASE = 8'h08;
	localparam logic [7:0] ADDR_DEC_BASE = 8'h10;
	localparam logic [7:0] ADDR_DEC_STRIDE = 8'h08;
	localparam int NUM_THREADS = 4;
	localparam int DEC_WIDTH = 56;
	////////////////////////////////////////////////////////////////////////
	// control/status field positions
	localparam int F_MODE_NATIVE = 0;
	localparam int F_OSC_16 = 1;
	localparam int F_SYNC_SEL_LO = 2;
	localparam int F_LOAD_CMD = 4;
	localparam int F_CLEAR_CMD = 5;
	localparam int F_TIMEOUT_LO = 16;
	localparam int F_RUNNING = 32;
	localparam int F_WAIT_SYNC = 33;
	localparam int F_ERR_PARITY = 34;
	localparam int F_ERR_STEP_COUNT = 35;
	localparam int F_ERR_MISSING = 36;
	localparam int F_ERR_SEQUENCE = 37;
	localparam int F_ERR_STATE = 38;
	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic RST_MODE_NATIVE = 1'h1;
	localparam logic RST_OSC_16 = 1'h0;
	localparam logic [1:0] RST_SYNC_SEL = 2'h1; // 2 us, tb bit 53
	localparam logic [15:0] RST_TIMEOUT = 16'h0100;
	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLOCK_MHZ = 20;
	localparam int FAST_MHZ = 500;
	// low-bit increments per core clock
	localparam logic [4:0] LOW_INC = 5'(FAST_MHZ / CLOCK_MHZ);
	localparam logic [8:0] STEPS_PER_US = 9'h020; // 32 MHz step
	////////////////////////////////////////////////////////////////////////
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT_SYNC = 4'h2,
		ST_RUN = 4'h4,
		ST_ERROR = 4'h8
	} ctbs_state_e;
	////////////////////////////////////////////////////////////////////////
	// expected steps per sync interval
	function automatic logic [8:0] steps_expected(input logic [1:0] sel);
		steps_expected = STEPS_PER_US << sel;
	endfunction : steps_expected

	// saturating add on the low four bits
	function automatic logic [3:0] low_sat_add(input logic [3:0] val);
		logic [5:0] sum; // room for 15 plus the increment, no wrap
		sum = {2'h0, val} + {1'h0, LOW_INC};
		low_sat_add = (sum > 6'h0f) ? 4'hf : sum[3:0];
	endfunction : low_sat_add
endpackage : ctbs_pkg

// ==== rtl/ctbs_step_gen.sv ====
`timescale 1ns/100ps
// turns oscillator and sync pins into one-cycle events
module ctbs_step_gen (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// pins
	input wire logic tod_osc,
	input wire logic tod_sync,
	// mode
	input wire logic osc_16,
	// events
	output logic step,
	output logic sync_evt
);
	logic [1:0] osc_sync_reg; // two-flop synchroniser
	logic [1:0] syn_sync_reg; // two-flop synchroniser
	logic osc_prev_reg; // previous settled level
	logic syn_prev_reg; // previous settled level

	////////////////////////////////////////////////////////////////////////
	// synchronise and remember levels
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osc_sync_reg <= 2'h0;
			syn_sync_reg <= 2'h0;
			osc_prev_reg <= 1'h0;
			syn_prev_reg <= 1'h0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[0], tod_osc};
			syn_sync_reg <= {syn_sync_reg[0], tod_sync};
			osc_prev_reg <= osc_sync_reg[1];
			syn_prev_reg <= syn_sync_reg[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slow oscillator steps on both edges, fast one on rising only
	always_comb begin
		if (osc_16) begin
			step = osc_sync_reg[1] ^ osc_prev_reg;
		end else begin
			step = osc_sync_reg[1] & ~osc_prev_reg;
		end
		sync_evt = syn_sync_reg[1] & ~syn_prev_reg;
	end
endmodule : ctbs_step_gen

// ==== rtl/ctbs_decr.sv ====
`timescale 1ns/100ps
// one per-thread decrementer
module ctbs_decr (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// software load
	input wire logic load,
	input wire logic [55:0] load_val,
	// time base tick
	input wire logic tick,
	// state
	output logic [55:0] value,
	output logic expired
);
	logic [55:0] value_reg; // counter

	////////////////////////////////////////////////////////////////////////
	// load wins over tick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			value_reg <= 56'h0;
		end else if (load) begin
			value_reg <= load_val;
		end else if (tick) begin
			value_reg <= value_reg - 56'h1;
		end
	end

	// sign bit marks expiry
	assign value = value_reg;
	assign expired = value_reg[55];
endmodule : ctbs_decr

// ==== rtl/ctbs_core.sv ====
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
// core time base with chip time synchronisation
module ctbs_core (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [63:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [63:0] rdata,
	// privilege of the accessing thread
	input wire logic hyp_state,
	// chip time link pins
	input wire logic tod_osc,
	input wire logic tod_sync,
	input wire logic [59:0] chip_time_of_day,
	// outputs
	output logic [63:0] core_time_base,
	output logic priv_int,
	output logic hmi,
	output logic [3:0] dec_expired
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	ctbs_pkg::ctbs_state_e state_reg; // sequencer
	ctbs_pkg::ctbs_state_e state_next;
	logic [63:0] tb_reg; // time base
	logic [63:0] tb_next;
	logic tb_par_reg; // stored parity of time base
	logic mode_native_reg; // control fields
	logic osc_16_reg;
	logic [1:0] sync_sel_reg;
	logic [15:0] timeout_reg;
	logic ctrl_par_reg; // stored parity of control fields
	logic err_par_reg, err_cnt_reg, err_miss_reg, err_seq_reg;
	logic [15:0] miss_cnt_reg; // cycles since last step
	logic [8:0] step_cnt_reg; // steps since last sync
	logic [8:0] cnt_now;
	logic [59:0] tod_s1_reg, tod_s2_reg; // chip time synchroniser
	logic step, sync_evt;
	logic cs_hit, tb_hit, cs_wr, tb_wr, cs_trap;
	logic ctrl_change, load_cmd, clear_cmd;
	logic set_par, set_cnt, set_miss, set_seq, err_any;
	logic [20:0] ctrl_bits;
	logic [63:0] status_word;
	localparam int NUM_T = ctbs_pkg::NUM_THREADS;
	logic [NUM_T-1:0] dec_load;
	logic [55:0] dec_val [NUM_T];

	////////////////////////////////////////////////////////////////////////
	// event sources
	ctbs_step_gen u_step (
		.clock(clock),
		.rst_b(rst_b),
		.tod_osc(tod_osc),
		.tod_sync(tod_sync),
		.osc_16(osc_16_reg),
		.step(step),
		.sync_evt(sync_evt)
	);

	// chip time passes two flops before use
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tod_s1_reg <= 60'h0;
			tod_s2_reg <= 60'h0;
		end else begin
			tod_s1_reg <= chip_time_of_day;
			tod_s2_reg <= tod_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode and access qualification
	always_comb begin
		cs_hit = 1'h0;
		tb_hit = 1'h0;
		if (addr == ctbs_pkg::ADDR_CTRL_STATUS) begin
			cs_hit = 1'h1;
		end else if (addr == ctbs_pkg::ADDR_TIME_BASE) begin
			tb_hit = 1'h1;
		end
	end
	assign cs_trap = cs_hit & (wr | rd) & ~hyp_state;
	assign cs_wr = cs_hit & wr & hyp_state;
	assign tb_wr = tb_hit & wr;
	assign load_cmd = cs_wr & wdata[ctbs_pkg::F_LOAD_CMD];
	assign clear_cmd = cs_wr & wdata[ctbs_pkg::F_CLEAR_CMD];
	assign ctrl_change = cs_wr & (
		wdata[ctbs_pkg::F_MODE_NATIVE] != mode_native_reg ||
		wdata[ctbs_pkg::F_OSC_16] != osc_16_reg ||
		wdata[ctbs_pkg::F_SYNC_SEL_LO +: 2] != sync_sel_reg);
	assign ctrl_bits = {timeout_reg, sync_sel_reg, osc_16_reg,
		mode_native_reg, ctrl_par_reg};

	////////////////////////////////////////////////////////////////////////
	// error detection
	assign cnt_now = step_cnt_reg + {8'h0, step};
	always_comb begin
		set_par = (^tb_reg != tb_par_reg) || (^ctrl_bits);
		set_cnt = (state_reg == ctbs_pkg::ST_RUN) && sync_evt &&
			cnt_now != ctbs_pkg::steps_expected(sync_sel_reg);
		set_miss = (state_reg == ctbs_pkg::ST_RUN) &&
			miss_cnt_reg > timeout_reg;
		set_seq = (state_reg != ctbs_pkg::ST_IDLE) &&
			(tb_wr || ctrl_change ||
			(load_cmd && state_reg != ctbs_pkg::ST_ERROR));
		err_any = set_par | set_cnt | set_miss | set_seq;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ctbs_pkg::ST_IDLE: begin
				if (err_any) begin
					state_next = ctbs_pkg::ST_ERROR;
				end else if (load_cmd) begin
					state_next = ctbs_pkg::ST_WAIT_SYNC;
				end
			end
			ctbs_pkg::ST_WAIT_SYNC: begin
				if (err_any) begin
					state_next = ctbs_pkg::ST_ERROR;
				end else if (sync_evt) begin
					state_next = ctbs_pkg::ST_RUN;
				end
			end
			ctbs_pkg::ST_RUN: begin
				if (err_any) begin
					state_next = ctbs_pkg::ST_ERROR;
				end
			end
			ctbs_pkg::ST_ERROR: begin
				if (clear_cmd) begin
					state_next = ctbs_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = ctbs_pkg::ST_ERROR;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ctbs_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// time base next value
	always_comb begin
		tb_next = tb_reg;
		if (state_reg == ctbs_pkg::ST_IDLE && tb_wr) begin
			tb_next = wdata; // load while idle only
		end else if (state_reg == ctbs_pkg::ST_WAIT_SYNC && sync_evt &&
			!err_any) begin
			tb_next = {tod_s2_reg, 4'h0};
		end else if (state_reg == ctbs_pkg::ST_RUN && !err_any) begin
			if (step) begin
				tb_next = {tb_reg[63:4] + 60'h1, 4'h0};
			end else if (mode_native_reg) begin
				tb_next[3:0] = ctbs_pkg::low_sat_add(tb_reg[3:0]);
			end
		end
	end

	// time base and its parity, frozen in error
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tb_reg <= 64'h0;
			tb_par_reg <= 1'h0;
		end else begin
			tb_reg <= tb_next;
			tb_par_reg <= ^tb_next;
		end
	end
	assign core_time_base = tb_reg;

	////////////////////////////////////////////////////////////////////////
	// control fields, writable only while idle; status is not written
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_native_reg <= ctbs_pkg::RST_MODE_NATIVE;
			osc_16_reg <= ctbs_pkg::RST_OSC_16;
			sync_sel_reg <= ctbs_pkg::RST_SYNC_SEL;
			timeout_reg <= ctbs_pkg::RST_TIMEOUT;
			ctrl_par_reg <= ^{ctbs_pkg::RST_TIMEOUT, ctbs_pkg::RST_SYNC_SEL,
				ctbs_pkg::RST_OSC_16, ctbs_pkg::RST_MODE_NATIVE};
		end else if (cs_wr && state_reg == ctbs_pkg::ST_IDLE) begin
			mode_native_reg <= wdata[ctbs_pkg::F_MODE_NATIVE];
			osc_16_reg <= wdata[ctbs_pkg::F_OSC_16];
			sync_sel_reg <= wdata[ctbs_pkg::F_SYNC_SEL_LO +: 2];
			timeout_reg <= wdata[ctbs_pkg::F_TIMEOUT_LO +: 16];
			ctrl_par_reg <= ^wdata[ctbs_pkg::F_TIMEOUT_LO +: 16] ^
				(^wdata[3:0]) ^ 1'h0; // covers fields above
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky causes; a set beats a clear in the same cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_par_reg <= 1'h0;
			err_cnt_reg <= 1'h0;
			err_miss_reg <= 1'h0;
			err_seq_reg <= 1'h0;
		end else begin
			err_par_reg <= (err_par_reg & ~clear_cmd) | set_par;
			err_cnt_reg <= (err_cnt_reg & ~clear_cmd) | set_cnt;
			err_miss_reg <= (err_miss_reg & ~clear_cmd) | set_miss;
			err_seq_reg <= (err_seq_reg & ~clear_cmd) | set_seq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// step and missing-step counters
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			miss_cnt_reg <= 16'h0;
			step_cnt_reg <= 9'h0;
		end else begin
			if (step || state_reg != ctbs_pkg::ST_RUN) begin
				miss_cnt_reg <= 16'h0;
			end else if (miss_cnt_reg != 16'hffff) begin
				miss_cnt_reg <= miss_cnt_reg + 16'h1;
			end
			if (sync_evt || state_reg != ctbs_pkg::ST_RUN) begin
				step_cnt_reg <= 9'h0;
			end else if (step && step_cnt_reg != 9'h1ff) begin
				step_cnt_reg <= step_cnt_reg + 9'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts as one-cycle pulses
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			priv_int <= 1'h0;
			hmi <= 1'h0;
		end else begin
			priv_int <= cs_trap;
			hmi <= (state_reg != ctbs_pkg::ST_ERROR) &&
				(state_next == ctbs_pkg::ST_ERROR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-thread decrementers tick on each step while running
	genvar t;
	generate
		for (t = 0; t < NUM_T; t++) begin : g_dec
			assign dec_load[t] = wr && addr == 8'(ctbs_pkg::ADDR_DEC_BASE +
				ctbs_pkg::ADDR_DEC_STRIDE * t);
			ctbs_decr u_dec (
				.clock(clock),
				.rst_b(rst_b),
				.load(dec_load[t]),
				.load_val(wdata[55:0]),
				.tick(step && state_reg == ctbs_pkg::ST_RUN),
				.value(dec_val[t]),
				.expired(dec_expired[t])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	always_comb begin
		status_word = 64'h0;
		status_word[ctbs_pkg::F_MODE_NATIVE] = mode_native_reg;
		status_word[ctbs_pkg::F_OSC_16] = osc_16_reg;
		status_word[ctbs_pkg::F_SYNC_SEL_LO +: 2] = sync_sel_reg;
		status_word[ctbs_pkg::F_TIMEOUT_LO +: 16] = timeout_reg;
		status_word[ctbs_pkg::F_RUNNING] = state_reg == ctbs_pkg::ST_RUN;
		status_word[ctbs_pkg::F_WAIT_SYNC] =
			state_reg == ctbs_pkg::ST_WAIT_SYNC;
		status_word[ctbs_pkg::F_ERR_PARITY] = err_par_reg;
		status_word[ctbs_pkg::F_ERR_STEP_COUNT] = err_cnt_reg;
		status_word[ctbs_pkg::F_ERR_MISSING] = err_miss_reg;
		status_word[ctbs_pkg::F_ERR_SEQUENCE] = err_seq_reg;
		status_word[ctbs_pkg::F_ERR_STATE] = state_reg == ctbs_pkg::ST_ERROR;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 64'h0;
		end else if (!rd) begin
			rdata <= 64'h0;
		end else if (cs_hit) begin
			rdata <= hyp_state ? status_word : 64'h0;
		end else if (tb_hit) begin
			rdata <= tb_reg;
		end else begin
			rdata <= 64'h0;
			for (int i = 0; i < NUM_T; i++) begin
				if (addr == 8'(ctbs_pkg::ADDR_DEC_BASE +
					ctbs_pkg::ADDR_DEC_STRIDE * i)) begin
					rdata <= {8'h0, dec_val[i]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_run_step;
		state_reg == ctbs_pkg::ST_RUN && step && !err_any;
	endsequence
	sequence s_wait_sync;
		state_reg == ctbs_pkg::ST_WAIT_SYNC && sync_evt && !err_any;
	endsequence

	step_advance_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_run_step |=> tb_reg[63:4] == $past(tb_reg[63:4]) + 60'h1)
		else $error("step did not advance time base");
	low_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_run_step |=> tb_reg[3:0] == 4'h0)
		else $error("low bits not cleared on step");
	low_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ctbs_pkg::ST_RUN && !step && !err_any &&
		tb_reg[3:0] == 4'hf |=> tb_reg[3:0] == 4'hf)
		else $error("saturated low bits moved");
	sync_load_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_wait_sync |=> tb_reg[63:4] == $past(tod_s2_reg) &&
		state_reg == ctbs_pkg::ST_RUN)
		else $error("sync did not load chip time");
	priv_trap_a: assert property (@(posedge clock) disable iff (!rst_b)
		cs_hit && wr && !hyp_state |=> priv_int && $stable(timeout_reg))
		else $error("unprivileged write not trapped");
	count_check_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ctbs_pkg::ST_RUN && sync_evt &&
		cnt_now != ctbs_pkg::steps_expected(sync_sel_reg)
		|=> err_cnt_reg ##1 state_reg == ctbs_pkg::ST_ERROR)
		else $error("step count mismatch missed");
	missing_step_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ctbs_pkg::ST_RUN && miss_cnt_reg > timeout_reg
		|=> err_miss_reg && hmi)
		else $error("missing step not flagged");
	error_freeze_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ctbs_pkg::ST_ERROR && !clear_cmd |=> $stable(tb_reg))
		else $error("time base moved in error");
	tb_write_a: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ctbs_pkg::ST_RUN && tb_wr |=> err_seq_reg && hmi
		##1 !hmi)
		else $error("bad time base write not caught");
	parity_err_a: assert property (@(posedge clock) disable iff (!rst_b)
		^tb_reg != tb_par_reg |=> err_par_reg)
		else $error("parity mismatch not reported");
endmodule : ctbs_core

// ==== testbench/ctbs_tod_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// chip time-of-day source: step oscillator, sync pulse, chip time
module ctbs_tod_model (
	// control from the bench
	input wire logic run,
	input wire logic [1:0] sync_sel,
	input wire logic osc_16,
	input wire logic extra_step,
	// link pins
	output logic tod_osc,
	output logic tod_sync,
	output logic [59:0] chip_time_of_day
);
	localparam int HALF_NS = 200; // half of the 400 ns step period
	int n; // steps in the current interval
	int k; // step index
	////////////////////////////////////////////////////////////////////////
	// one step; oscillator stands still while run is low
	task automatic do_step(input logic last);
		wait (run);
		tod_sync = 1'b0;
		chip_time_of_day = chip_time_of_day + 60'h1;
		tod_osc = osc_16 ? ~tod_osc : 1'b1;
		#(HALF_NS);
		if (!osc_16) begin
			tod_osc = 1'b0;
		end
		// sync rises mid-step, chip time settled long before
		tod_sync = last;
		#(HALF_NS);
	endtask : do_step
	////////////////////////////////////////////////////////////////////////
	// intervals of 32 << sel steps, one more when asked to misbehave
	initial begin
		tod_osc = 1'b0;
		tod_sync = 1'b0;
		chip_time_of_day = 60'h0;
		#7;
		forever begin
			n = (32 << sync_sel) + (extra_step ? 1 : 0);
			for (k = 1; k <= n; k++) begin
				do_step(k == n);
			end
		end
	end
endmodule : ctbs_tod_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// self-checking bench for the core time base
module tb;
	logic clock;
	logic rst_b;
	logic [7:0] addr;
	logic [63:0] wdata;
	logic wr;
	logic rd;
	logic [63:0] rdata;
	logic hyp_state;
	logic tod_osc;
	logic tod_sync;
	logic [59:0] chip_time_of_day;
	logic [63:0] core_time_base;
	logic priv_int;
	logic hmi;
	logic [3:0] dec_expired;
	logic run; // model control
	logic [1:0] sync_sel;
	logic osc_16;
	logic extra_step;
	int err_total;
	int compares;
	int hmi_total; // hmi pulses seen
	logic priv_seen; // priv_int in the read data cycle
	logic [63:0] v; // read scratch
	logic [63:0] cfg; // control word of this pass
	logic [63:0] hold; // frozen time base
	logic [63:0] exp_err; // expected error bits
	logic nat;
	int i;
	int j;
	localparam logic [7:0] CTRL = ctbs_pkg::ADDR_CTRL_STATUS;
	////////////////////////////////////////////////////////////////////////
	ctbs_core dut_u (.clock(clock), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.hyp_state(hyp_state), .tod_osc(tod_osc), .tod_sync(tod_sync),
		.chip_time_of_day(chip_time_of_day),
		.core_time_base(core_time_base), .priv_int(priv_int), .hmi(hmi),
		.dec_expired(dec_expired));
	ctbs_tod_model model_u (.run(run), .sync_sel(sync_sel),
		.osc_16(osc_16), .extra_step(extra_step), .tod_osc(tod_osc),
		.tod_sync(tod_sync), .chip_time_of_day(chip_time_of_day));
	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock and hmi pulse counter
	initial clock = 1'b0;
	always #25 clock = ~clock;
	always @(posedge clock) begin
		if (hmi === 1'b1) begin
			hmi_total <= hmi_total + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// register bus tasks and comparison
	task automatic wr_reg(input logic [7:0] a, input logic [63:0] d,
		input logic h);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		hyp_state <= h;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic h,
		output logic [63:0] d);
		@(posedge clock);
		addr <= a;
		hyp_state <= h;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
		priv_seen = priv_int;
	endtask : rd_reg
	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// poll a status bit, bounded by reads
	task automatic wait_bit(input int idx, input int lim);
		for (int k = 0; k < lim; k++) begin
			rd_reg(CTRL, 1'b1, v);
			if (v[idx] === 1'b1) begin
				break;
			end
		end
		// a poll that runs out counts as a mismatch
		check("poll limit", 64'(v[idx]), 64'h1);
	endtask : wait_bit
	task automatic wrap_up;
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	// watchdog: the passes need about 11000 clocks
	initial begin
		#(50 * 40000);
		err_total++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 64'h0;
		wr = 1'b0;
		rd = 1'b0;
		hyp_state = 1'b1;
		run = 1'b1;
		sync_sel = 2'h0;
		osc_16 = 1'b0;
		extra_step = 1'b0;
		err_total = 0;
		compares = 0;
		hmi_total = 0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		rd_reg(CTRL, 1'b1, v);
		check("ctrl reset", v, 64'h0000_0000_0100_0005);
		// guest accesses are refused
		wr_reg(CTRL, 64'hffff_ffff_ffff_ffff, 1'b0);
		rd_reg(CTRL, 1'b0, v);
		check("guest read", v, 64'h0);
		check("priv pulse", 64'(priv_seen), 64'h1);
		rd_reg(CTRL, 1'b1, v);
		check("after guest", v, 64'h0000_0000_0100_0005);
		check("no priv", 64'(priv_seen), 64'h0);
		rd_reg(8'h40, 1'b1, v);
		check("unmapped", v, 64'h0);
		// status fields ignore writes; timeout of 32 cycles
		wr_reg(CTRL, 64'h0000_007f_0020_0005, 1'b1);
		rd_reg(CTRL, 1'b1, v);
		check("status write", v, 64'h0000_0000_0020_0005);
		// one pass per sync interval, each ended by an error; passes 0 and 3 both end by a sequence error
		for (i = 0; i < 4; i++) begin
			nat = (i != 2);
			sync_sel <= 2'(i);
			osc_16 <= i[0];
			cfg = 64'h0020_0000 | (64'(i) << 2) | (64'(i[0]) << 1) | 64'(nat);
			wr_reg(CTRL, cfg, 1'b1);
			wr_reg(CTRL, cfg | 64'h10, 1'b1);
			wait_bit(ctbs_pkg::F_RUNNING, 1200);
			repeat (16 * (32 << i) + 16) @(posedge clock);
			rd_reg(CTRL, 1'b1, v);
			check("run status", v & ~64'h30, cfg | 64'h1_0000_0000);
			@(chip_time_of_day);
			repeat (6) @(posedge clock);
			#1;
			check("tb vs chip", 64'(core_time_base[63:4]),
				64'(chip_time_of_day));
			check("low held", 64'(core_time_base[3:0]),
				nat ? 64'hf : 64'h0);
			if (nat) begin
				@(core_time_base[4]);
				#1;
				check("low clear", 64'(core_time_base[3:0]), 64'h0);
				@(posedge clock);
				#1;
				check("low fast", 64'(core_time_base[3:0]), 64'hf);
			end
			j = hmi_total;
			case (i)
				0: begin
					for (int t = 0; t < 4; t++) begin
						wr_reg(8'(ctbs_pkg::ADDR_DEC_BASE + t * 8),
							(t == 0) ? 64'h1 : 64'h100, 1'b1);
					end
					repeat (100) @(posedge clock);
					#1;
					check("dec expired", 64'(dec_expired), 64'h1);
					wr_reg(ctbs_pkg::ADDR_TIME_BASE, 64'h0, 1'b1);
					exp_err = 64'h1 << ctbs_pkg::F_ERR_SEQUENCE;
				end
				1: begin
					extra_step <= 1'b1;
					exp_err = 64'h1 << ctbs_pkg::F_ERR_STEP_COUNT;
				end
				2: begin
					run <= 1'b0;
					exp_err = 64'h1 << ctbs_pkg::F_ERR_MISSING;
				end
				default: begin
					wr_reg(CTRL, cfg ^ 64'h4, 1'b1);
					exp_err = 64'h1 << ctbs_pkg::F_ERR_SEQUENCE;
				end
			endcase
			exp_err = exp_err | (64'h1 << ctbs_pkg::F_ERR_STATE);
			wait_bit(ctbs_pkg::F_ERR_STATE, 1500);
			extra_step <= 1'b0;
			run <= 1'b1;
			check("error cause", v & 64'h7e_0000_0000, exp_err);
			check("hmi pulse", 64'(hmi_total - j), 64'h1);
			#1;
			hold = core_time_base;
			repeat (40) @(posedge clock);
			#1;
			check("tb frozen", core_time_base, hold);
			rd_reg(CTRL, 1'b1, v);
			check("sticky", v & 64'h7e_0000_0000, exp_err);
			wr_reg(CTRL, cfg | 64'h20, 1'b1);
			rd_reg(CTRL, 1'b1, v);
			check("cleared", v & 64'h7f_0000_0000, 64'h0);
		end
		wrap_up();
	end
endmodule : tb
